// >>> swsc_pkg.sv
// Constants and types for the standby/wake state control block.
// Assumes a single 25 MHz clock and an active-high asynchronous power-on reset.
//
// What this block does and expects of the outside wake logic
// R1: State pin shows run indicator or clock-enable indicator, chosen by select bit.
// R2: Run indicator: pin high when Operating or Idle, low in Standby.
// R3: Clock-enable indicator: pin driven low only in Standby, released otherwise.
// R4: Wake-up input is deglitched so short pulses never wake the system.
// R5: Outside wake logic holds wake-up high at least 125 us.
// R6: Detected wake in Standby moves to Operating; ignored in Idle or Operating.
// R7: Wake-up may be ignored up to two seconds after power-on reset release.
// R8: Outside wake logic raises wake-up for 125 us after that two seconds.
// R9: User reset is active low, deglitched, and requests a system reset.
// R10: User reset and two test straps captured at power-on release select test modes.
// R11: User reset never clears the real-time clock; only power-on reset does.
// R12: Configuration straps, boot select included, captured at power-on release and held.
// R13: Power-on reset resets everything, real-time clock too, even for one cycle.
// R14: Deglitched low power-fail input forces Standby.
// R15: Low battery-good in Standby blocks start-up despite a wake request.
// R16: Deglitched inputs are synchronised and accepted after a fixed stable count.
package swsc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WAKE_HOLD_NS    = 125000;
  // Filter shorter than the guaranteed hold so a 125 us pulse is always seen
  localparam int WAKE_FILT_NS    = 100000;
  localparam int INPUT_FILT_NS   = 4000;
  localparam int WAKE_IGNORE_MS  = 2000;
  localparam int NS_PER_MS       = 1000000;

  localparam int DG_CNT_W        = 12;
  localparam logic [DG_CNT_W-1:0] WAKE_FILT_CYC =
    DG_CNT_W'((WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DG_CNT_W-1:0] INPUT_FILT_CYC =
    DG_CNT_W'((INPUT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int GUARD_W         = 26;
  localparam int WAKE_IGNORE_CYC = (WAKE_IGNORE_MS / CLK_PERIOD_NS) * NS_PER_MS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DG_CNT_W-1:0] DG_CNT_RST = 12'h000;
  localparam logic [GUARD_W-1:0]  GUARD_RST  = 26'h0000000;
  localparam logic [2:0]          TEST_RST   = 3'h7;
  localparam logic                PIN_SEL_RUN = 1'b0;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_standby,
    st_operating,
    st_idle
  } swsc_state_type;

endpackage : swsc_pkg

// >>> swsc_deglitch.sv
// Two-flop synchroniser followed by a stability filter for one input.
// Assumes the input is a slow level from a pin or button.
`timescale 1ns/1ps
`default_nettype none

module swsc_deglitch
  import swsc_pkg::*;
#(
  parameter logic [DG_CNT_W-1:0] STABLE_CYCLES = 12'h064,
  parameter logic                RESET_LEVEL   = 1'b0
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic raw_i,
  output var  logic level_o
);

  logic                meta_q;
  logic                sync_q;
  logic                level_q;
  logic                level_d;
  logic [DG_CNT_W-1:0] cnt_q;
  logic [DG_CNT_W-1:0] cnt_d;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  always_comb begin
    level_d = level_q;
    cnt_d   = DG_CNT_RST;
    if (sync_q != level_q) begin
      // A change must persist the full count; any bounce restarts it
      if (cnt_q >= STABLE_CYCLES - 12'h001) begin
        level_d = sync_q; // R16
      end else begin
        cnt_d = cnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q  <= RESET_LEVEL;
      sync_q  <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
      cnt_q   <= DG_CNT_RST;
    end else begin
      meta_q  <= raw_i;
      sync_q  <= meta_q; // R16
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level_o = level_q;

endmodule : swsc_deglitch

`default_nettype wire

// >>> swsc_top.sv
// Power-state control: standby/operating/idle, wake-up, user reset and straps.
// Assumes reset_i is the inverted power-on reset pin and all pins are
// already synchronous to ref_clk_i; filters still resynchronise them.
`timescale 1ns/1ps
`default_nettype none

module swsc_top
  import swsc_pkg::*;
#(
  parameter int WAKE_IGNORE_CYCLES = WAKE_IGNORE_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       wakeup_i,
  input  wire logic       user_reset_n_i,
  input  wire logic       power_fail_n_i,
  input  wire logic       battery_good_i,
  input  wire logic [1:0] test_mode_strap_n_i,
  input  wire logic       media_change_boot_sel_n_i,
  input  wire logic       state_pin_select_i,
  input  wire logic       sw_standby_req_i,
  input  wire logic       sw_idle_req_i,
  input  wire logic       idle_exit_i,
  output var  logic       state_ctl_o,
  output var  logic       state_ctl_oe_n_o,
  output var  swsc_state_type state_o,
  output var  logic       system_reset_o,
  output var  logic       rtc_reset_o,
  output var  logic [2:0] test_mode_o,
  output var  logic       boot_rom_sel_o,
  output var  logic       straps_valid_o,
  output var  logic       media_change_n_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_active(input swsc_state_type st);
    is_active = (st != st_standby);
  endfunction : is_active

  // ----------------------------------------------------------------
  // Input filters
  // ----------------------------------------------------------------
  logic wake_lvl;
  logic user_reset_n_lvl;
  logic power_fail_n_lvl;
  logic battery_good_lvl;
  logic media_change_n_lvl;

  swsc_deglitch #(
    .STABLE_CYCLES (WAKE_FILT_CYC),
    .RESET_LEVEL   (1'b0)
  ) u_dg_wake (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (wakeup_i),
    .level_o   (wake_lvl)
  ); // R4

  swsc_deglitch #(
    .STABLE_CYCLES (INPUT_FILT_CYC),
    .RESET_LEVEL   (1'b1)
  ) u_dg_ureset (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (user_reset_n_i),
    .level_o   (user_reset_n_lvl)
  ); // R9

  swsc_deglitch #(
    .STABLE_CYCLES (INPUT_FILT_CYC),
    .RESET_LEVEL   (1'b1)
  ) u_dg_pwrfail (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (power_fail_n_i),
    .level_o   (power_fail_n_lvl)
  );

  swsc_deglitch #(
    .STABLE_CYCLES (INPUT_FILT_CYC),
    .RESET_LEVEL   (1'b1)
  ) u_dg_battery_good (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (battery_good_i),
    .level_o   (battery_good_lvl)
  );

  swsc_deglitch #(
    .STABLE_CYCLES (INPUT_FILT_CYC),
    .RESET_LEVEL   (1'b1)
  ) u_dg_media (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (media_change_boot_sel_n_i),
    .level_o   (media_change_n_lvl)
  );

  // ----------------------------------------------------------------
  // Wake guard after power-on
  // ----------------------------------------------------------------
  // Wake edges inside the guard are dropped, not queued; the outside
  // logic must present a fresh pulse once the guard has run out.
  logic [GUARD_W-1:0] guard_q;
  logic [GUARD_W-1:0] guard_d;
  logic               guard_done;

  always_comb begin
    guard_done = (guard_q >= GUARD_W'(WAKE_IGNORE_CYCLES));
    guard_d    = guard_q;
    if (!guard_done) begin
      guard_d = guard_q + 26'h0000001; // R7
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      guard_q <= GUARD_RST;
    end else begin
      guard_q <= guard_d;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  swsc_state_type state_q;
  swsc_state_type state_d;
  logic           wake_prev_q;
  logic           wake_prev_d;
  logic           wake_rise;

  always_comb begin
    wake_prev_d = wake_lvl;
    // Edge, not level: a wake line left high must not undo a software standby
    wake_rise   = wake_lvl && !wake_prev_q;
    state_d     = state_q;
    case (state_q)
      st_standby: begin
        // Low battery holds the system down even with a valid wake
        if (wake_rise && guard_done && battery_good_lvl) begin // R6 R7 R15
          state_d = st_operating;
        end
      end
      st_operating: begin
        if (sw_standby_req_i) begin
          state_d = st_standby;
        end else if (sw_idle_req_i) begin
          state_d = st_idle;
        end
      end
      st_idle: begin
        if (sw_standby_req_i) begin
          state_d = st_standby;
        end else if (idle_exit_i) begin
          state_d = st_operating;
        end
      end
      default: begin
        state_d = st_standby;
      end
    endcase
    if (!power_fail_n_lvl) begin
      state_d = st_standby; // R14
    end
  end

  // Power-on reset puts the system in Standby; a wake after the guard, with battery good, brings it up
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q     <= st_standby; // R13
      wake_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      wake_prev_q <= wake_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // State pin and state output
  // ----------------------------------------------------------------
  logic state_ctl_q;
  logic state_ctl_d;
  logic state_ctl_oe_n_q;
  logic state_ctl_oe_n_d;

  always_comb begin
    if (state_pin_select_i == PIN_SEL_RUN) begin // R1
      state_ctl_d      = is_active(state_d); // R2
      state_ctl_oe_n_d = 1'b0;
    end else begin
      // Clock-enable indicator: pull low in Standby, release otherwise
      state_ctl_d      = 1'b0;
      state_ctl_oe_n_d = is_active(state_d); // R3
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ctl_q      <= 1'b0;
      state_ctl_oe_n_q <= 1'b0;
    end else begin
      state_ctl_q      <= state_ctl_d;
      state_ctl_oe_n_q <= state_ctl_oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------
  logic system_reset_q;
  logic system_reset_d;
  logic rtc_reset_q;
  logic rtc_reset_d;

  always_comb begin
    system_reset_d = !user_reset_n_lvl; // R9
    // Real-time clock is cleared by power-on reset alone
    rtc_reset_d    = 1'b0; // R11
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      system_reset_q <= 1'b1; // R13
      rtc_reset_q    <= 1'b1; // R13
    end else begin
      system_reset_q <= system_reset_d;
      rtc_reset_q    <= rtc_reset_d;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture at power-on release
  // ----------------------------------------------------------------
  // Async reset cannot load pin values, so the straps are taken on the
  // first clock edge after release and then frozen.
  logic       straps_valid_q;
  logic       straps_valid_d;
  logic [2:0] test_mode_q;
  logic [2:0] test_mode_d;
  logic       boot_rom_q;
  logic       boot_rom_d;

  always_comb begin
    straps_valid_d = 1'b1;
    test_mode_d    = test_mode_q;
    boot_rom_d     = boot_rom_q;
    if (!straps_valid_q) begin
      test_mode_d = {user_reset_n_i, test_mode_strap_n_i}; // R10
      boot_rom_d  = !media_change_boot_sel_n_i; // R12
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      straps_valid_q <= 1'b0;
      test_mode_q    <= TEST_RST;
      boot_rom_q     <= 1'b0;
    end else begin
      straps_valid_q <= straps_valid_d;
      test_mode_q    <= test_mode_d;
      boot_rom_q     <= boot_rom_d;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic media_change_n_q;
  logic media_change_n_d;

  always_comb begin
    media_change_n_d = media_change_n_lvl; // R16
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      media_change_n_q <= 1'b1;
    end else begin
      media_change_n_q <= media_change_n_d;
    end
  end

  assign state_ctl_o      = state_ctl_q;
  assign state_ctl_oe_n_o = state_ctl_oe_n_q;
  assign state_o          = state_q;
  assign system_reset_o   = system_reset_q;
  assign rtc_reset_o      = rtc_reset_q;
  assign test_mode_o      = test_mode_q;
  assign boot_rom_sel_o   = boot_rom_q;
  assign straps_valid_o   = straps_valid_q;
  assign media_change_n_o = media_change_n_q;

endmodule : swsc_top

`default_nettype wire

// >>> swsc_top_monitor.sv
// Checker on the pins of the standby/wake state control block.
// Assumes it is bound to swsc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module swsc_top_monitor
  import swsc_pkg::*;
#(
  parameter int WAKE_IGNORE_CYCLES = WAKE_IGNORE_CYC
) (
  input wire logic           ref_clk_i,
  input wire logic           reset_i,
  input wire logic           wakeup_i,
  input wire logic           user_reset_n_i,
  input wire logic           power_fail_n_i,
  input wire logic           battery_good_i,
  input wire logic [1:0]     test_mode_strap_n_i,
  input wire logic           media_change_boot_sel_n_i,
  input wire logic           state_pin_select_i,
  input wire logic           state_ctl_o,
  input wire logic           state_ctl_oe_n_o,
  input wire swsc_state_type state_o,
  input wire logic           system_reset_o,
  input wire logic           rtc_reset_o,
  input wire logic [2:0]     test_mode_o,
  input wire logic           boot_rom_sel_o,
  input wire logic           straps_valid_o
);
  // ----------------------------------------------------------------
  // Level age counters, saturating so long holds never wrap
  // ----------------------------------------------------------------
  logic [11:0] wake_hi_q, wake_hi_d, ures_lo_q, ures_lo_d;
  logic [11:0] pf_lo_q, pf_lo_d, bat_lo_q, bat_lo_d;

  function automatic logic [11:0] sat_count(logic [11:0] c, logic hit);
    return !hit ? 12'h000 : ((c == 12'hFFF) ? c : c + 12'h001);
  endfunction : sat_count

  always_comb begin
    wake_hi_d = sat_count(wake_hi_q, wakeup_i);
    ures_lo_d = sat_count(ures_lo_q, !user_reset_n_i);
    pf_lo_d   = sat_count(pf_lo_q, !power_fail_n_i);
    bat_lo_d  = sat_count(bat_lo_q, !battery_good_i);
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_hi_q <= 12'h000;
      ures_lo_q <= 12'h000;
      pf_lo_q   <= 12'h000;
      bat_lo_q  <= 12'h000;
    end else begin
      wake_hi_q <= wake_hi_d;
      ures_lo_q <= ures_lo_d;
      pf_lo_q   <= pf_lo_d;
      bat_lo_q  <= bat_lo_d;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_leave_standby;
    state_o == st_standby ##1 state_o != st_standby;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_run_pin_level: assert property (
    !state_pin_select_i && !$past(state_pin_select_i)
    |-> state_ctl_o == (state_o != st_standby) && !state_ctl_oe_n_o)
    else $error("run indicator does not follow the power state");
  a_clock_enable_indicator_pin_drive: assert property (
    state_pin_select_i && $past(state_pin_select_i)
    |-> !state_ctl_o && state_ctl_oe_n_o == (state_o != st_standby))
    else $error("clock enable indicator drives low outside standby");
  // Margin below the filter length keeps this safe against sync latency
  a_wake_filtered: assert property (
    s_leave_standby |-> state_o == st_operating && $past(wake_hi_q, 3) >= 12'h7D0)
    else $error("standby left without a long wake request");
  a_fail_forces_standby: assert property (
    pf_lo_q >= 12'h06E |-> state_o == st_standby)
    else $error("power fail did not force standby");
  a_battery_blocks_wake: assert property (
    state_o == st_standby && bat_lo_q >= 12'h06E |=> state_o == st_standby)
    else $error("start up with battery low");
  a_user_reset_seen: assert property (
    ures_lo_q >= 12'h06E |-> system_reset_o)
    else $error("user reset not passed on");
  a_rtc_only_por: assert property (
    !$past(reset_i) |-> !rtc_reset_o)
    else $error("clock reset outside power on reset");
  a_reset_values: assert property (disable iff (1'b0)
    reset_i |-> state_o == st_standby && system_reset_o && rtc_reset_o && !straps_valid_o)
    else $error("wrong outputs during power on reset");
  a_strap_capture: assert property (
    $rose(straps_valid_o) |-> test_mode_o == {$past(user_reset_n_i), $past(test_mode_strap_n_i)}
    && boot_rom_sel_o == !$past(media_change_boot_sel_n_i))
    else $error("straps not taken at reset release");
  a_straps_held: assert property (
    straps_valid_o && $past(straps_valid_o) |-> $stable(test_mode_o) && $stable(boot_rom_sel_o))
    else $error("captured straps changed");
endmodule : swsc_top_monitor

bind swsc_top swsc_top_monitor #(.WAKE_IGNORE_CYCLES(WAKE_IGNORE_CYCLES)) u_monitor (
  .ref_clk_i, .reset_i, .wakeup_i, .user_reset_n_i, .power_fail_n_i, .battery_good_i,
  .test_mode_strap_n_i, .media_change_boot_sel_n_i, .state_pin_select_i, .state_ctl_o,
  .state_ctl_oe_n_o, .state_o, .system_reset_o, .rtc_reset_o, .test_mode_o,
  .boot_rom_sel_o, .straps_valid_o
);

`default_nettype wire

// >>> swsc_board_model.sv
// Board side model: wake circuit, user reset button, supply sense and straps.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module swsc_board_model
  import swsc_pkg::*;
(
  input  wire logic       ref_clk_i,
  output var  logic       wakeup_o,
  output var  logic       user_reset_n_o,
  output var  logic       power_fail_n_o,
  output var  logic       battery_good_o,
  output var  logic [1:0] test_mode_strap_n_o,
  output var  logic       media_change_boot_sel_n_o
);
  initial begin
    wakeup_o = 1'b0;
    user_reset_n_o = 1'b1;
    power_fail_n_o = 1'b1;
    battery_good_o = 1'b1;
    test_mode_strap_n_o = 2'h2;
    media_change_boot_sel_n_o = 1'b0;
  end

  // Short pulses only when the bench asks for a bad request
  task automatic wake_pulse(input logic good);
    wakeup_o = 1'b1;
    repeat (good ? WAKE_HOLD_NS / CLK_PERIOD_NS : 1000) @(posedge ref_clk_i);
    #1;
    wakeup_o = 1'b0;
    // Long low gap so the next rise is a fresh request
    repeat (2600) @(posedge ref_clk_i);
    #1;
  endtask : wake_pulse

  task automatic set_supply(input logic ures_n, input logic pf_n, input logic bat);
    user_reset_n_o = ures_n;
    power_fail_n_o = pf_n;
    battery_good_o = bat;
  endtask : set_supply

  task automatic set_straps(input logic [1:0] strap_n, input logic med_n);
    test_mode_strap_n_o = strap_n;
    media_change_boot_sel_n_o = med_n;
  endtask : set_straps
endmodule : swsc_board_model

`default_nettype wire

// >>> swsc_top_tb.sv
// Self-checking bench for swsc_top with the board model on its pins.
// Assumes a 25 MHz clock and a wake guard shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module swsc_top_tb
  import swsc_pkg::*;
;
  logic           ref_clk_i, reset_i, sel, sby_req, idle_req, idle_exit;
  logic           wake, ures_n, pf_n, bat, med_n, ctl, oe_n, sys_rst, rtc_rst;
  logic           boot, valid, media_n;
  logic [1:0]     strap_n;
  logic [2:0]     tmode;
  swsc_state_type st;
  int             err_count = 0;
  int             tests_run = 0;
  int             cyc = 0;

  swsc_top #(.WAKE_IGNORE_CYCLES(20)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .wakeup_i(wake), .user_reset_n_i(ures_n),
    .power_fail_n_i(pf_n), .battery_good_i(bat), .test_mode_strap_n_i(strap_n),
    .media_change_boot_sel_n_i(med_n), .state_pin_select_i(sel), .sw_standby_req_i(sby_req),
    .sw_idle_req_i(idle_req), .idle_exit_i(idle_exit), .state_ctl_o(ctl),
    .state_ctl_oe_n_o(oe_n), .state_o(st), .system_reset_o(sys_rst), .rtc_reset_o(rtc_rst),
    .test_mode_o(tmode), .boot_rom_sel_o(boot), .straps_valid_o(valid),
    .media_change_n_o(media_n));

  swsc_board_model u_board (
    .ref_clk_i(ref_clk_i), .wakeup_o(wake), .user_reset_n_o(ures_n), .power_fail_n_o(pf_n),
    .battery_good_o(bat), .test_mode_strap_n_o(strap_n), .media_change_boot_sel_n_o(med_n));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step

  task automatic final_report;
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // One cycle software request: 0 standby, 1 idle, 2 idle exit
  task automatic sw(input int which);
    {idle_exit, idle_req, sby_req} = 3'h1 << which;
    step(1);
    {idle_exit, idle_req, sby_req} = 3'h0;
    step(1);
  endtask : sw

  // Pin mode change, then let the registered pin settle
  task automatic set_sel(input logic clock_enable_indicator);
    sel = clock_enable_indicator;
    step(2);
  endtask : set_sel

  task automatic t_power_on;
    `CHK("state in reset", st_standby, st)
    `CHK("clock reset in reset", 1'b1, rtc_rst)
    reset_i = 1'b0;
    step(2);
    `CHK("test mode", 3'h6, tmode)
    `CHK("boot rom select", 1'b1, boot)
    `CHK("clock reset", 1'b0, rtc_rst)
    `CHK("run pin standby", 1'b0, ctl)
    step(30);
  endtask : t_power_on

  task automatic t_gated_wakes;
    u_board.wake_pulse(1'b0);
    `CHK("short pulse", st_standby, st)
    u_board.set_supply(1'b1, 1'b1, 1'b0);
    step(150);
    u_board.wake_pulse(1'b1);
    `CHK("battery low", st_standby, st)
    u_board.set_supply(1'b1, 1'b1, 1'b1);
    step(150);
    u_board.wake_pulse(1'b1);
    `CHK("wake", st_operating, st)
    `CHK("run pin high", 1'b1, ctl)
    `CHK("run pin driven", 1'b0, oe_n)
  endtask : t_gated_wakes

  task automatic t_midrun_reset;
    u_board.set_straps(2'h1, 1'b1);
    reset_i = 1'b1;
    step(1);
    `CHK("clock reset", 1'b1, rtc_rst)
    `CHK("state", st_standby, st)
    reset_i = 1'b0;
    step(2);
    `CHK("test mode", 3'h5, tmode)
    `CHK("boot rom select", 1'b0, boot)
    step(30);
  endtask : t_midrun_reset

  task automatic t_clock_enable_indicator_idle;
    u_board.wake_pulse(1'b1);
    set_sel(1'b1);
    `CHK("clock enable released", 1'b1, oe_n)
    `CHK("clock enable level", 1'b0, ctl)
    sw(1);
    `CHK("idle", st_idle, st)
    u_board.wake_pulse(1'b1);
    `CHK("wake in idle", st_idle, st)
    sw(2);
    `CHK("idle exit", st_operating, st)
    sw(1);
    sw(0);
    `CHK("standby", st_standby, st)
    `CHK("clock enable low", 1'b0, oe_n)
    set_sel(1'b0);
    `CHK("run pin standby", 1'b0, ctl)
  endtask : t_clock_enable_indicator_idle

  task automatic t_fail_and_user;
    u_board.set_straps(2'h2, 1'b0);
    u_board.wake_pulse(1'b1);
    `CHK("media change filtered", 1'b0, media_n)
    `CHK("test mode held", 3'h5, tmode)
    `CHK("boot select held", 1'b0, boot)
    u_board.set_supply(1'b1, 1'b0, 1'b1);
    step(150);
    `CHK("power fail", st_standby, st)
    u_board.set_supply(1'b0, 1'b1, 1'b1);
    step(150);
    `CHK("user reset", 1'b1, sys_rst)
    `CHK("clock kept", 1'b0, rtc_rst)
    u_board.set_supply(1'b1, 1'b1, 1'b1);
    step(150);
    `CHK("user reset gone", 1'b0, sys_rst)
    sw(1);
    `CHK("idle refused in standby", st_standby, st)
  endtask : t_fail_and_user

  // Ceiling well above the roughly 33000 cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    reset_i = 1'b1;
    {sel, sby_req, idle_req, idle_exit} = 4'h0;
    step(16);
    t_power_on();
    t_gated_wakes();
    t_midrun_reset();
    t_clock_enable_indicator_idle();
    t_fail_and_user();
    final_report();
  end
endmodule : swsc_top_tb

`default_nettype wire
